//--- pmr_asserts.sv
// wire-level checks on the shared management clock and data line
`timescale 1ns/1ps
module pmr_asserts (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic mdc,
   input wire logic mdio_host_o,
   input wire logic mdio_host_oe,
   input wire logic mdio_dev_o,
   input wire logic mdio_dev_oe,
   input wire logic mdio
);
   import pmr_pkg::*;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // ---------------------------------------------
   // helper: cycles the controller has driven
   // ---------------------------------------------
   logic [9:0] drive_cnt;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         drive_cnt <= 10'h000;
      end else begin
         drive_cnt <= mdio_host_oe ? drive_cnt + 10'h001 : 10'h000;
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   sequence s_ta_float;
      !mdio_dev_oe [*8];
   endsequence
   sequence s_data_span;
      ##[270:274] $fell(mdio_dev_oe);
   endsequence
   property p_one_driver;
      mdio_dev_oe |-> !mdio_host_oe && mdio == mdio_dev_o;
   endproperty
   property p_preamble;
      mdio_host_oe && drive_cnt < 10'h200 |-> mdio_host_o;
   endproperty
   property p_start_zero;
      mdio_host_oe && drive_cnt == 10'h200 |-> !mdio_host_o;
   endproperty
   property p_ta_float;
      $fell(mdio_host_oe) |-> s_ta_float;
   endproperty
   property p_ta_zero;
      $rose(mdio_dev_oe) |-> !mdio_dev_o && mdc;
   endproperty
   property p_data_span;
      $rose(mdio_dev_oe) |-> s_data_span;
   endproperty
   property p_mdc_half;
      $rose(mdc) |-> mdc [*8] ##1 !mdc;
   endproperty
   property p_dev_on_rise;
      mdio_dev_oe && $changed(mdio_dev_o) |-> mdc;
   endproperty
   property p_host_on_fall;
      mdio_host_oe && $past(mdio_host_oe) && $changed(mdio_host_o) |-> $fell(mdc);
   endproperty
   a_one_driver: assert property (p_one_driver)
      else $error("two drivers on data wire");
   a_preamble: assert property (p_preamble)
      else $error("preamble bit not one");
   a_start_zero: assert property (p_start_zero)
      else $error("start bit after preamble not zero");
   a_ta_float: assert property (p_ta_float)
      else $error("first turnaround bit driven");
   a_ta_zero: assert property (p_ta_zero)
      else $error("second turnaround bit not zero");
   a_data_span: assert property (p_data_span)
      else $error("read data span wrong length");
   a_mdc_half: assert property (p_mdc_half)
      else $error("clock high phase wrong length");
   a_dev_on_rise: assert property (p_dev_on_rise)
      else $error("read data changed while clock low");
   a_host_on_fall: assert property (p_host_on_fall)
      else $error("controller bit changed off falling clock");
endmodule : pmr_asserts

//--- pmr_dev.sv
// transceiver end: serial frame decoder and control/status/identifier registers
`timescale 1ns/1ps
// Behaviour
// RQ1 - single speed part fixes speed bit
// RQ2 - negotiation enabled overrides manual speed, duplex
// RQ3 - no negotiation ability: enable reads zero
// RQ4 - power down keeps management, silences outputs
// RQ5 - clocks run once powerdown, isolate clear
// RQ6 - isolate ignores inputs, floats data outputs
// RQ7 - isolate bit resets to one
// RQ8 - restart needs ability and enable set
// RQ9 - restart reads one until negotiation starts
// RQ10 - single duplex fixed; ignored in loopback
// RQ11 - collision test: collision follows transmit enable
// RQ12 - reserved bits zero, status writes ignored
// RQ13 - complete reads zero without active negotiation
// RQ14 - remote fault latches high, clears on read
// RQ15 - link status latches low until read
// RQ16 - jabber latches high, clears on read
// RQ17 - unimplemented registers: no drive, no effect
// RQ18 - registers two, three hold identifier
// RQ19 - idle high, 32 ones before frame
// RQ20 - address zero device, registers zero, one
// RQ21 - read turnaround: float, then drive zero
// RQ22 - data shifted most significant bit first
// RQ23 - start, opcode, addresses, turnaround, sixteen bits
// RQ24 - sample on management clock rising edge
module pmr_dev #(
   parameter logic [4:0] PHY_ADDR = 5'h00,
   parameter bit HAS_AN = 1'b1,
   parameter bit DUAL_SPEED = 1'b1,
   parameter bit FIXED_SPEED = 1'b1,
   parameter bit DUAL_DUPLEX = 1'b1,
   parameter bit FIXED_DUPLEX = 1'b1,
   parameter bit HAS_RFAULT = 1'b1,
   parameter bit HAS_JABBER = 1'b0,
   parameter logic [4:0] ABILITY = 5'h0f,
   // identifier values are arbitrary
   parameter logic [21:0] ORG_CODE = 22'h0a5a5a,
   parameter logic [5:0] MODEL = 6'h15,
   parameter logic [3:0] REVISION = 4'h1
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   pmr_if.dev mif,
   input wire logic link_up_i,
   input wire logic rfault_i,
   input wire logic jabber_i,
   input wire logic an_done_i,
   input wire logic an_started_i,
   input wire logic an_speed_i,
   input wire logic an_duplex_i,
   input wire logic tx_en_i,
   output logic speed_o,
   output logic duplex_o,
   output logic loopback_o,
   output logic power_down_o,
   output logic isolate_o,
   output logic an_restart_o,
   output logic col_o,
   output logic col_oe_o,
   output logic data_oe_o,
   output logic clk_run_o
);
   import pmr_pkg::*;
   // ------------------------------------------------------------
   // reset image
   // ------------------------------------------------------------
   // RQ7 isolated out of reset
   localparam pmr_dev_s RST = '{
      st: D_PRE,
      an_en: HAS_AN,
      iso: CTL_ISOLATE_RST,
      speed: FIXED_SPEED,
      duplex: FIXED_DUPLEX,
      speed_o: FIXED_SPEED,
      duplex_o: FIXED_DUPLEX,
      link_lat: LINK_LAT_RST,
      default: '0
   };
   pmr_dev_s r;
   pmr_dev_s n;
   logic [1:0] sy_lvl;
   logic [1:0] sy_rise;
   logic b;
   logic [12:0] hv;
   logic [15:0] wv;
   logic [15:0] rv;
   if (ABILITY == 5'h00) begin : g_bad_ability
      $error("pmr_dev needs at least one ability bit");
   end
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // RQ17 only four registers answer
   function automatic logic implemented(input logic [4:0] ra);
      implemented = ra <= REG_ID_LOW;
   endfunction : implemented
   function automatic logic [15:0] rd_word(input logic [4:0] ra, input pmr_dev_s s,
                                           input logic done);
      logic [31:0] id;
      id = {ORG_CODE, MODEL, REVISION};
      case (ra)
         // RQ12 reserved control bits zero
         REG_CONTROL: rd_word = {1'b0, s.loop, s.speed, s.an_en, s.pdown, s.iso,
                                 s.restart, s.duplex, s.coltest, 7'h00};
         // RQ13 complete gated by enable
         REG_STATUS: rd_word = {ABILITY, 5'h00, s.an_en & done, s.rfault, HAS_AN,
                                s.link_lat, s.jabber, 1'b1};
         // RQ18 identifier split high, low
         REG_ID_HIGH: rd_word = id[31:16];
         REG_ID_LOW: rd_word = id[15:0];
         default: rd_word = 16'h0000;
      endcase
   endfunction : rd_word
   // ------------------------------------------------------------
   // pin filters
   // ------------------------------------------------------------
   pmr_sync #(
      .W(2)
   ) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .pin_i({mif.mdio, mif.mdc}),
      .lvl_o(sy_lvl),
      .rise_o(sy_rise)
   );
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      b = sy_lvl[1];
      hv = {r.hdr[11:0], b};
      wv = {r.shreg[14:0], b};
      rv = rd_word(r.hdr[4:0], r, an_done_i);
      // RQ9 start acknowledge self-clears
      if (an_started_i) begin
         n.restart = 1'b0;
      end
      // RQ24 advance on clock rise only
      if (sy_rise[0]) begin
         case (r.st)
            D_PRE: begin
               // RQ19 need 32 ones in a row
               if (b) begin
                  if (r.pre_cnt != 6'(PREAMBLE_LEN)) begin
                     n.pre_cnt = r.pre_cnt + 6'h01;
                  end
               end else if (r.pre_cnt == 6'(PREAMBLE_LEN)) begin
                  n.st = D_HDR;
                  n.bit_cnt = 4'h0;
                  n.pre_cnt = 6'h00;
               end else begin
                  n.pre_cnt = 6'h00;
               end
            end
            D_HDR: begin
               n.hdr = hv;
               n.bit_cnt = r.bit_cnt + 4'h1;
               if (r.bit_cnt == 4'(HDR_BITS - 1)) begin
                  n.bit_cnt = 4'h0;
                  // RQ23 second start bit and opcode
                  n.rd = hv[11:10] == OP_READ;
                  if (hv[12] == FRAME_START[0] && (n.rd || hv[11:10] == OP_WRITE)) begin
                     n.st = D_TA;
                  end else begin
                     n.st = D_PRE;
                  end
                  // RQ20 own address, known register
                  n.sel = hv[9:5] == PHY_ADDR && implemented(hv[4:0]);
               end
            end
            D_TA: begin
               if (r.bit_cnt == 4'h0) begin
                  n.bit_cnt = 4'h1;
                  // RQ21 drive zero for second bit
                  n.mdio_oe = r.rd & r.sel;
                  n.mdio_o = 1'b0;
               end else begin
                  n.st = D_DATA;
                  n.bit_cnt = 4'h0;
                  // RQ22 bit 15 goes first
                  n.mdio_o = rv[15];
                  n.shreg = {rv[14:0], 1'b0};
                  // RQ14 read clears latched bits
                  if (r.rd && r.sel && r.hdr[4:0] == REG_STATUS) begin
                     n.rfault = 1'b0;
                     n.link_lat = 1'b1;
                     n.jabber = 1'b0;
                  end
               end
            end
            D_DATA: begin
               n.bit_cnt = r.bit_cnt + 4'h1;
               n.shreg = wv;
               n.mdio_o = r.shreg[15];
               if (r.bit_cnt == 4'(DATA_BITS - 1)) begin
                  n.st = D_PRE;
                  n.bit_cnt = 4'h0;
                  n.mdio_oe = 1'b0;
                  // RQ12 only control is writable
                  if (!r.rd && r.sel && r.hdr[4:0] == REG_CONTROL) begin
                     if (wv[CTL_RESET]) begin
                        n.loop = RST.loop;
                        n.speed = RST.speed;
                        n.an_en = RST.an_en;
                        n.pdown = RST.pdown;
                        n.iso = RST.iso;
                        n.restart = RST.restart;
                        n.duplex = RST.duplex;
                        n.coltest = RST.coltest;
                        n.rfault = 1'b0;
                        n.link_lat = RST.link_lat;
                        n.jabber = 1'b0;
                     end else begin
                        n.loop = wv[CTL_LOOP];
                        // RQ1 fixed speed ignores writes
                        n.speed = DUAL_SPEED ? wv[CTL_SPEED] : FIXED_SPEED;
                        // RQ3 enable stuck low without ability
                        n.an_en = HAS_AN & wv[CTL_AN_EN];
                        n.pdown = wv[CTL_PDOWN];
                        n.iso = wv[CTL_ISOLATE];
                        // RQ10 fixed duplex ignores writes
                        n.duplex = DUAL_DUPLEX ? wv[CTL_DUPLEX] : FIXED_DUPLEX;
                        n.coltest = wv[CTL_COLTEST];
                        // RQ8 restart only when able and enabled
                        if (!(HAS_AN & wv[CTL_AN_EN])) begin
                           n.restart = 1'b0;
                        end else if (wv[CTL_RESTART]) begin
                           n.restart = 1'b1;
                        end
                     end
                  end
               end
            end
            default: begin
               n.st = D_PRE;
            end
         endcase
      end
      // latch sets after clears: an event never lost to a read
      // RQ14 remote fault holds high
      if (HAS_RFAULT && rfault_i) begin
         n.rfault = 1'b1;
      end
      // RQ15 link failure holds low
      if (!link_up_i) begin
         n.link_lat = 1'b0;
      end
      // RQ16 jabber holds high
      if (HAS_JABBER && jabber_i) begin
         n.jabber = 1'b1;
      end
      // RQ2 negotiated values override manual bits
      n.speed_o = n.an_en ? an_speed_i : n.speed;
      // RQ10 loopback forces full duplex
      n.duplex_o = n.loop ? 1'b1 : (n.an_en ? an_duplex_i : n.duplex);
      // RQ6 isolated: float outputs, drop inputs
      n.out_oe = ~n.iso;
      // RQ4 power down silences collision
      // RQ11 one cycle, well inside 4 bit times
      n.col_o = n.coltest & tx_en_i & ~n.iso & ~n.pdown;
      // RQ5 clocks start at once, inside the limit
      n.clk_run_o = ~n.pdown & ~n.iso;
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign mif.mdio_dev_o = r.mdio_o;
   assign mif.mdio_dev_oe = r.mdio_oe;
   assign speed_o = r.speed_o;
   assign duplex_o = r.duplex_o;
   assign loopback_o = r.loop;
   assign power_down_o = r.pdown;
   assign isolate_o = r.iso;
   assign an_restart_o = r.restart;
   assign col_o = r.col_o;
   assign col_oe_o = r.out_oe;
   assign data_oe_o = r.out_oe;
   assign clk_run_o = r.clk_run_o;
endmodule : pmr_dev

//--- pmr_host.sv
// controller end: clock divider and frame shifter for register reads and writes
`timescale 1ns/1ps
module pmr_host #(
   parameter int HALF = 8
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   pmr_if.host mif,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [4:0] req_phy_i,
   input wire logic [4:0] req_reg_i,
   input wire logic [15:0] req_data_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic rsp_nodrive_o,
   output logic [15:0] rsp_data_o
);
   import pmr_pkg::*;
   pmr_host_s r;
   pmr_host_s n;
   logic mi;
   logic [5:0] nidx;
   // the far end answers about nine cycles after a rise
   if (HALF < 8 || HALF > 255) begin : g_bad_half
      $error("pmr_host HALF must lie in 8..255");
   end
   pmr_sync #(
      .W(1)
   ) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .pin_i(mif.mdio),
      .lvl_o(mi),
      .rise_o()
   );
   always_comb begin
      n = r;
      n.rsp_valid = 1'b0;
      nidx = r.idx + 6'h01;
      case (r.st)
         H_IDLE: begin
            // RQ19 wire released between frames
            n.oe = 1'b0;
            n.mdc = 1'b0;
            n.ready = 1'b1;
            if (req_valid_i && r.ready) begin
               n.ready = 1'b0;
               // RQ23 preamble, start, opcode, addresses, turnaround
               // RQ12 unused data bits sent as zero
               n.frame = {32'hffff_ffff, FRAME_START, req_write_i ? OP_WRITE : OP_READ,
                          req_phy_i, req_reg_i, req_write_i ? TA_WRITE : 2'h0,
                          req_write_i ? req_data_i : 16'h0000};
               n.rd = ~req_write_i;
               n.idx = 6'h00;
               n.div = 8'h00;
               n.nodrive = 1'b0;
               n.mdio_o = 1'b1;
               n.oe = 1'b1;
               n.st = H_LOW;
            end
         end
         H_LOW: begin
            n.div = r.div + 8'h01;
            if (r.div == 8'(HALF - 1)) begin
               n.div = 8'h00;
               n.mdc = 1'b1;
               n.st = H_HIGH;
               // RQ21 device zero expected here
               if (r.idx == 6'(IDX_TA2)) begin
                  n.nodrive = mi;
               end
               // RQ22 first bit in is bit 15
               if (r.idx >= 6'(IDX_DATA)) begin
                  n.rdata = {r.rdata[14:0], mi};
               end
            end
         end
         H_HIGH: begin
            n.div = r.div + 8'h01;
            if (r.div == 8'(HALF - 1)) begin
               n.div = 8'h00;
               n.mdc = 1'b0;
               if (r.idx == 6'(IDX_LAST)) begin
                  n.st = H_IDLE;
                  n.oe = 1'b0;
                  n.ready = 1'b1;
                  n.rsp_valid = 1'b1;
                  n.rsp_data = r.rd ? r.rdata : 16'h0000;
                  n.rsp_nodrive = r.rd & r.nodrive;
               end else begin
                  n.st = H_LOW;
                  n.idx = nidx;
                  n.frame = {r.frame[62:0], 1'b0};
                  n.mdio_o = r.frame[62];
                  // RQ21 reads release the wire at turnaround
                  n.oe = ~(r.rd && nidx >= 6'(IDX_TA1));
               end
            end
         end
         default: begin
            n.st = H_IDLE;
         end
      endcase
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign mif.mdc = r.mdc;
   assign mif.mdio_host_o = r.mdio_o;
   assign mif.mdio_host_oe = r.oe;
   assign req_ready_o = r.ready;
   assign rsp_valid_o = r.rsp_valid;
   assign rsp_nodrive_o = r.rsp_nodrive;
   assign rsp_data_o = r.rsp_data;
endmodule : pmr_host

//--- pmr_if.sv
// management clock and shared data wire between controller and transceiver
`timescale 1ns/1ps
interface pmr_if;
   logic mdc;
   logic mdio_host_o;
   logic mdio_host_oe;
   logic mdio_dev_o;
   logic mdio_dev_oe;
   logic mdio;
   // pull-up holds the idle wire high
   assign mdio = mdio_host_oe ? mdio_host_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);
   modport dev (input mdc, input mdio, output mdio_dev_o, output mdio_dev_oe);
   modport host (output mdc, input mdio, output mdio_host_o, output mdio_host_oe);
endinterface : pmr_if

//--- pmr_pkg.sv
// constants and state types shared by both ends of the management link
package pmr_pkg;
   // ------------------------------------------------------------
   // frame layout
   // ------------------------------------------------------------
   localparam int PREAMBLE_LEN = 32;
   localparam int HDR_BITS = 13;
   localparam int DATA_BITS = 16;
   localparam int IDX_TA1 = 46;
   localparam int IDX_TA2 = 47;
   localparam int IDX_DATA = 48;
   localparam int IDX_LAST = 63;
   localparam logic [1:0] FRAME_START = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   // ------------------------------------------------------------
   // register map and control fields
   // ------------------------------------------------------------
   localparam logic [4:0] REG_CONTROL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_ID_HIGH = 5'h02;
   localparam logic [4:0] REG_ID_LOW = 5'h03;
   localparam int CTL_RESET = 15;
   localparam int CTL_LOOP = 14;
   localparam int CTL_SPEED = 13;
   localparam int CTL_AN_EN = 12;
   localparam int CTL_PDOWN = 11;
   localparam int CTL_ISOLATE = 10;
   localparam int CTL_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam int CTL_COLTEST = 7;
   localparam logic CTL_ISOLATE_RST = 1'b1;
   localparam logic LINK_LAT_RST = 1'b0;
   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      D_PRE = 2'h0,
      D_HDR = 2'h1,
      D_TA = 2'h3,
      D_DATA = 2'h2
   } pmr_dst_e;
   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_LOW = 2'h1,
      H_HIGH = 2'h3
   } pmr_hst_e;
   typedef struct packed {
      pmr_dst_e st;
      logic [5:0] pre_cnt;
      logic [3:0] bit_cnt;
      logic [12:0] hdr;
      logic rd;
      logic sel;
      logic [15:0] shreg;
      logic loop;
      logic speed;
      logic an_en;
      logic pdown;
      logic iso;
      logic restart;
      logic duplex;
      logic coltest;
      logic rfault;
      logic link_lat;
      logic jabber;
      logic mdio_o;
      logic mdio_oe;
      logic speed_o;
      logic duplex_o;
      logic out_oe;
      logic col_o;
      logic clk_run_o;
   } pmr_dev_s;
   typedef struct packed {
      pmr_hst_e st;
      logic [7:0] div;
      logic [5:0] idx;
      logic rd;
      logic [63:0] frame;
      logic [15:0] rdata;
      logic nodrive;
      logic mdc;
      logic mdio_o;
      logic oe;
      logic ready;
      logic rsp_valid;
      logic rsp_nodrive;
      logic [15:0] rsp_data;
   } pmr_host_s;
endpackage : pmr_pkg

//--- pmr_sync.sv
// three-stage input filter with rising-edge pulse
`timescale 1ns/1ps
module pmr_sync #(
   parameter int W = 1
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] lvl_o,
   output logic [W-1:0] rise_o
);
   import pmr_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
   } pmr_sync_s;
   pmr_sync_s r;
   pmr_sync_s n;
   if (W < 1) begin : g_bad_w
      $error("pmr_sync width must be at least one");
   end
   always_comb begin
      n = r;
      n.s1 = pin_i;
      n.s2 = r.s1;
      n.s3 = r.s2;
      // level moves only when stages two and three agree
      n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
      n.rise = n.lvl & ~r.lvl;
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign lvl_o = r.lvl;
   assign rise_o = r.rise;
endmodule : pmr_sync

//--- testbench.sv
// self-checking bench: controller end talks to transceiver end
`timescale 1ns/1ps
module testbench;
   import pmr_pkg::*;
   // identifier values are arbitrary
   localparam logic [21:0] ORG = 22'h012345;
   localparam logic [31:0] ID = {ORG, 6'h2a, 4'h3};
   typedef struct packed {
      logic wr;
      logic [4:0] ph;
      logic [4:0] rg;
      logic [15:0] wd;
      logic [15:0] exp;
      logic nd;
   } pmr_row_s;
   pmr_row_s rows [14] = '{
      '{1'b0, 5'h00, 5'h00, 16'h0000, 16'h3500, 1'b0},
      '{1'b0, 5'h00, 5'h02, 16'h0000, ID[31:16], 1'b0},
      '{1'b0, 5'h00, 5'h03, 16'h0000, ID[15:0], 1'b0},
      '{1'b0, 5'h00, 5'h04, 16'h0000, 16'h0000, 1'b1},
      '{1'b0, 5'h01, 5'h00, 16'h0000, 16'h0000, 1'b1},
      '{1'b1, 5'h00, 5'h00, 16'h0100, 16'h0000, 1'b0},
      '{1'b1, 5'h00, 5'h01, 16'hf83f, 16'h0000, 1'b0},
      '{1'b1, 5'h00, 5'h05, 16'hffff, 16'h0000, 1'b0},
      '{1'b1, 5'h01, 5'h00, 16'hffff, 16'h0000, 1'b0},
      '{1'b0, 5'h00, 5'h00, 16'h0000, 16'h0100, 1'b0},
      '{1'b0, 5'h00, 5'h01, 16'h0000, 16'h7809, 1'b0},
      '{1'b0, 5'h00, 5'h01, 16'h0000, 16'h780d, 1'b0},
      '{1'b1, 5'h00, 5'h00, 16'h0200, 16'h0000, 1'b0},
      '{1'b0, 5'h00, 5'h00, 16'h0000, 16'h0000, 1'b0}
   };
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic link_up_i = 1'b1;
   logic rfault_i = 1'b0;
   logic jabber_i = 1'b0;
   logic an_done_i = 1'b1;
   logic an_started_i = 1'b0;
   logic an_speed_i = 1'b1;
   logic an_duplex_i = 1'b0;
   logic tx_en_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [4:0] req_phy_i = 5'h00;
   logic [4:0] req_reg_i = 5'h00;
   logic [15:0] req_data_i = 16'h0000;
   logic speed_o, duplex_o, loopback_o, power_down_o, isolate_o, an_restart_o;
   logic col_o, col_oe_o, data_oe_o, clk_run_o, req_ready_o, rsp_valid_o, rsp_nodrive_o;
   logic [15:0] rsp_data_o;
   int n_fail = 0;
   int comparisons = 0;
   pmr_if mif ();
   pmr_dev #(.ORG_CODE(ORG), .MODEL(6'h2a), .REVISION(4'h3)) pmr_dev_i (.clock_i, .rst_b_i,
      .mif, .link_up_i, .rfault_i, .jabber_i, .an_done_i, .an_started_i, .an_speed_i,
      .an_duplex_i, .tx_en_i, .speed_o, .duplex_o, .loopback_o, .power_down_o, .isolate_o,
      .an_restart_o, .col_o, .col_oe_o, .data_oe_o, .clk_run_o);
   pmr_host pmr_host_i (.clock_i, .rst_b_i, .mif, .req_valid_i, .req_write_i, .req_phy_i,
      .req_reg_i, .req_data_i, .req_ready_o, .rsp_valid_o, .rsp_nodrive_o, .rsp_data_o);
   pmr_asserts pmr_asserts_i (.clock_i, .rst_b_i, .mdc(mif.mdc), .mdio(mif.mdio),
      .mdio_host_o(mif.mdio_host_o), .mdio_host_oe(mif.mdio_host_oe),
      .mdio_dev_o(mif.mdio_dev_o), .mdio_dev_oe(mif.mdio_dev_oe));
   initial begin
      forever #20 clock_i = ~clock_i;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // a frame takes 1024 cycles, so 2000 is a safe bound
   task automatic xfer(input logic wr, input logic [4:0] ph, input logic [4:0] rg,
                       input logic [15:0] wd);
      int n;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 2000) begin
         @(posedge clock_i);
         n++;
      end
      req_write_i <= wr;
      req_phy_i <= ph;
      req_reg_i <= rg;
      req_data_i <= wd;
      req_valid_i <= 1'b1;
      @(posedge clock_i);
      req_valid_i <= 1'b0;
      do begin
         @(posedge clock_i);
         n++;
      end while (rsp_valid_o !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         n_fail++;
         end_of_test();
      end
   endtask : xfer
   task automatic rd(input logic [4:0] rg, input logic [15:0] exp);
      xfer(1'b0, 5'h00, rg, 16'h0000);
      chk(rsp_data_o, exp);
   endtask : rd
   task automatic pulse_after(input logic [2:0] m);
      {an_started_i, rfault_i, tx_en_i} <= m;
      @(posedge clock_i);
      {an_started_i, rfault_i, tx_en_i} <= 3'h0;
      repeat (3) @(posedge clock_i);
   endtask : pulse_after
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) begin
         xfer(rows[i].wr, rows[i].ph, rows[i].rg, rows[i].wd);
         chk({15'h0000, rsp_nodrive_o}, {15'h0000, rows[i].nd});
         if (!rows[i].nd) chk(rsp_data_o, rows[i].exp);
      end
      $display("table rows done");
      chk({12'h000, speed_o, duplex_o, isolate_o, clk_run_o}, 16'h0001);
      xfer(1'b1, 5'h00, 5'h00, 16'h1200);
      repeat (3) @(posedge clock_i);
      chk({14'h0000, speed_o, an_restart_o}, 16'h0003);
      rd(5'h00, 16'h1200);
      pulse_after(3'h4);
      rd(5'h00, 16'h1000);
      rd(5'h01, 16'h782d);
      pulse_after(3'h2);
      // brief link drop; the latch must hold it until read
      link_up_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      link_up_i <= 1'b1;
      rd(5'h01, 16'h7839);
      rd(5'h01, 16'h782d);
      $display("latch test done");
      // keep isolate clear, else collision output is held off
      xfer(1'b1, 5'h00, 5'h00, 16'h1080);
      pulse_after(3'h1);
      tx_en_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk({14'h0000, col_o, col_oe_o}, 16'h0003);
      tx_en_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk({15'h0000, col_o}, 16'h0000);
      xfer(1'b1, 5'h00, 5'h00, 16'h1880);
      tx_en_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk({13'h0000, col_o, clk_run_o, power_down_o}, 16'h0001);
      rd(5'h00, 16'h1880);
      tx_en_i <= 1'b0;
      xfer(1'b1, 5'h00, 5'h00, 16'h4000);
      repeat (3) @(posedge clock_i);
      chk({14'h0000, loopback_o, duplex_o}, 16'h0003);
      $display("control test done");
      pulse_after(3'h2);
      xfer(1'b1, 5'h00, 5'h00, 16'h8000);
      rd(5'h00, 16'h3500);
      rd(5'h01, 16'h7829);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk({13'h0000, isolate_o, data_oe_o, clk_run_o}, 16'h0004);
      rst_b_i <= 1'b1;
      rd(5'h00, 16'h3500);
      $display("reset test done");
      end_of_test();
   end
endmodule : testbench
